// >>> core/serial_clock_and_buffer_config.sv
// serial channel clock selection, baud generation and buffer arrangement
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module serial_clock_and_buffer_config
  import serial_clock_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // serial clock pin
  input  wire logic        i_sclk_in,
  output logic             o_sclk_out,
  output logic             o_sclk_oe_n,
  // clock pulses to the shift logic
  output logic             o_serial_bit_clock,
  output logic             o_shift_tick,
  // buffer arrangement
  output logic             o_tx_double,
  output logic             o_rx_double,
  output logic             o_fifo_en,
  output logic [2:0]       o_rx_fifo_depth,
  output logic [2:0]       o_tx_fifo_depth
);

  typedef struct packed {
    // software settings
    logic [3:0]  baud_n;       // integer ratio
    logic [1:0]  baud_input_select;
    logic        frac_en;      // fractional division enable
    logic [3:0]  frac_k;       // fraction term
    logic [1:0]  serial_mode_field;
    logic [1:0]  uart_clock_source;
    logic        sclk_ext;     // serial clock from the pin
    logic        edge_fall;    // shift on falling edge
    logic        buf_double;   // buffer mode bit
    logic        fifo_enable_bit;
    logic [1:0]  duplex;       // fifo arrangement
    logic [15:0] timer_compare_value;
    // bus tracking
    logic        wr_pend;      // write data phase due
    logic        rd_wait;      // read data being fetched
    logic [7:0]  addr;         // latched byte address
    logic [31:0] rdata;        // read data
    // clock generation
    logic [6:0]  pre_cnt;      // prescaler counter
    logic [15:0] tmr_cnt;      // timer counter
    logic        tmr_ff;       // timer flip-flop
    logic        s1;           // pin synchroniser first
    logic        s2;           // pin synchroniser second
    logic        s3;           // edge history
    logic        sclk_out;     // driven serial clock
    logic [3:0]  bit_cnt;      // uart sixteen count
    logic        src_tick;     // selected clock pulse
    logic        shift_tick;   // bit or shift pulse
  } cfg_state_t;

  cfg_state_t st;
  cfg_state_t next_st;

  div_if dv ();

  logic        io_mode;     // i/o interface mode
  logic        tap_tick;    // chosen prescaler tap
  logic        ext_rise;    // pin rising edge
  logic        ext_fall;    // pin falling edge
  logic        tmr_match;   // timer compare hit
  logic        addr_take;   // address phase accepted
  logic        uart_tick;   // uart source pulse
  logic [31:0] rd_mux;      // read data selection
  logic [2:0]  rx_depth;    // receive fifo bytes
  logic [2:0]  tx_depth;    // transmit fifo bytes
  logic        fifo_on;     // fifo active

  baud_divider u_div (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .dv        (dv.div)
  );

  // divider inputs
  assign dv.n       = st.baud_n;
  assign dv.k       = st.frac_k;
  assign dv.frac_en = st.frac_en && !io_mode;
  assign dv.tick_in = tap_tick;

  assign io_mode = (st.serial_mode_field == MODE_IO);

  // prescaler tap selection
  always_comb
  begin
    if (st.baud_input_select == 2'h0)
      tap_tick = ((st.pre_cnt & TAP_MASK_2) == TAP_MASK_2);
    else if (st.baud_input_select == 2'h1)
      tap_tick = ((st.pre_cnt & TAP_MASK_8) == TAP_MASK_8);
    else if (st.baud_input_select == 2'h2)
      tap_tick = ((st.pre_cnt & TAP_MASK_32) == TAP_MASK_32);
    else
      tap_tick = ((st.pre_cnt & TAP_MASK_128) == TAP_MASK_128);
  end

  // pin edges seen after the synchroniser
  assign ext_rise = st.s2 && !st.s3;
  assign ext_fall = !st.s2 && st.s3;
  assign tmr_match = (st.tmr_cnt >= st.timer_compare_value);

  // uart source clock selection
  always_comb
  begin
    case (clk_src_t'(st.uart_clock_source))
      SRC_TIMER: uart_tick = tmr_match && !st.tmr_ff;
      SRC_BAUD:  uart_tick = dv.tick_out;
      SRC_FSYS:  uart_tick = 1'b1;
      default:   uart_tick = ext_rise;
    endcase
  end

  // fifo arrangement
  always_comb
  begin
    fifo_on = st.buf_double && st.fifo_enable_bit;
    rx_depth = 3'h0;
    tx_depth = 3'h0;
    case (duplex_t'(st.duplex))
      DPX_RX:   rx_depth = FIFO_FULL_DEPTH;
      DPX_TX:   tx_depth = FIFO_FULL_DEPTH;
      DPX_FULL:
      begin
        rx_depth = FIFO_HALF_DEPTH;
        tx_depth = FIFO_HALF_DEPTH;
      end
      default:  rx_depth = 3'h0;
    endcase
    if (!fifo_on)
    begin
      rx_depth = 3'h0;
      tx_depth = 3'h0;
    end
  end

  // register read selection
  always_comb
  begin
    rd_mux = RST_ZERO;
    if (st.addr == OFS_BAUD_CONTROL)
    begin
      rd_mux[BRC_N_LSB +: 4]   = st.baud_n;
      rd_mux[BRC_SEL_LSB +: 2] = st.baud_input_select;
      rd_mux[BRC_FRAC_BIT]     = st.frac_en;
    end
    else if (st.addr == OFS_BAUD_FRACTION)
      rd_mux[3:0] = st.frac_k;
    else if (st.addr == OFS_MODE_ZERO)
    begin
      rd_mux[MZ_SRC_LSB +: 2]  = st.uart_clock_source;
      rd_mux[MZ_MODE_LSB +: 2] = st.serial_mode_field;
    end
    else if (st.addr == OFS_CHANNEL_CONTROL)
    begin
      rd_mux[CCR_EXT_BIT]  = st.sclk_ext;
      rd_mux[CCR_EDGE_BIT] = st.edge_fall;
    end
    else if (st.addr == OFS_MODE_TWO)
      rd_mux[0] = st.buf_double;
    else if (st.addr == OFS_FIFO_CONFIG)
      rd_mux[0] = st.fifo_enable_bit;
    else if (st.addr == OFS_MODE_ONE)
      rd_mux[1:0] = st.duplex;
    else if (st.addr == OFS_TIMER_COMPARE)
      rd_mux[15:0] = st.timer_compare_value;
    else if (st.addr == OFS_STATUS)
    begin
      rd_mux[ST_TXD_BIT]      = o_tx_double;
      rd_mux[ST_RXD_BIT]      = o_rx_double;
      rd_mux[ST_FIFO_BIT]     = fifo_on;
      rd_mux[ST_RXF_LSB +: 3] = rx_depth;
      rd_mux[ST_TXF_LSB +: 3] = tx_depth;
      rd_mux[ST_SCLK_BIT]     = st.sclk_out;
    end
    else
      rd_mux = RST_ZERO;
  end

  assign addr_take = i_hsel && i_htrans[1] && i_hready;

  // next state of the whole block
  always_comb
  begin
    next_st = st;
    // bus address phase
    if (addr_take)
    begin
      next_st.addr    = {i_haddr[7:2], 2'b00};
      next_st.wr_pend = i_hwrite;
      next_st.rd_wait = !i_hwrite;
    end
    else if (i_hready)
    begin
      next_st.wr_pend = 1'b0;
    end
    // read data is captured in the wait cycle
    if (st.rd_wait)
    begin
      next_st.rdata   = rd_mux;
      next_st.rd_wait = 1'b0;
    end
    // write data phase
    if (st.wr_pend)
    begin
      if (st.addr == OFS_BAUD_CONTROL)
      begin
        next_st.baud_n            = i_hwdata[BRC_N_LSB +: 4];
        next_st.baud_input_select = i_hwdata[BRC_SEL_LSB +: 2];
        next_st.frac_en           = i_hwdata[BRC_FRAC_BIT];
      end
      else if (st.addr == OFS_BAUD_FRACTION)
        next_st.frac_k = i_hwdata[3:0];
      else if (st.addr == OFS_MODE_ZERO)
      begin
        next_st.uart_clock_source = i_hwdata[MZ_SRC_LSB +: 2];
        next_st.serial_mode_field = i_hwdata[MZ_MODE_LSB +: 2];
      end
      else if (st.addr == OFS_CHANNEL_CONTROL)
      begin
        next_st.sclk_ext  = i_hwdata[CCR_EXT_BIT];
        next_st.edge_fall = i_hwdata[CCR_EDGE_BIT];
      end
      else if (st.addr == OFS_MODE_TWO)
        next_st.buf_double = i_hwdata[0];
      else if (st.addr == OFS_FIFO_CONFIG)
        next_st.fifo_enable_bit = i_hwdata[0];
      else if (st.addr == OFS_MODE_ONE)
        next_st.duplex = i_hwdata[1:0];
      else if (st.addr == OFS_TIMER_COMPARE)
        next_st.timer_compare_value = i_hwdata[15:0];
      else
        next_st.duplex = st.duplex;
    end
    // free-running prescaler
    next_st.pre_cnt = st.pre_cnt + 7'h01;
    // timer flip-flop toggles on each match
    if (tmr_match)
    begin
      next_st.tmr_cnt = 16'h0001;
      next_st.tmr_ff  = !st.tmr_ff;
    end
    else
      next_st.tmr_cnt = st.tmr_cnt + 16'h0001;
    // pin synchroniser and edge history
    next_st.s1 = i_sclk_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // clock pulses to the shift logic
    next_st.src_tick   = 1'b0;
    next_st.shift_tick = 1'b0;
    if (io_mode)
    begin
      next_st.bit_cnt = 4'h0;
      if (!st.sclk_ext)
      begin
        // halve baud output, shift on rise
        if (dv.tick_out)
        begin
          next_st.sclk_out   = !st.sclk_out;
          next_st.src_tick   = 1'b1;
          next_st.shift_tick = !st.sclk_out;
        end
      end
      else
      begin
        next_st.sclk_out = 1'b0;
        if (st.edge_fall ? ext_fall : ext_rise)
        begin
          next_st.src_tick   = 1'b1;
          next_st.shift_tick = 1'b1;
        end
      end
    end
    else
    begin
      next_st.sclk_out = 1'b0;
      if (uart_tick)
      begin
        next_st.src_tick   = 1'b1;
        next_st.bit_cnt    = st.bit_cnt + 4'h1;
        next_st.shift_tick = (st.bit_cnt == BIT_LAST);
      end
    end
  end

  // state register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      st <= '0;
    else
      st <= next_st;
  end

  // bus answers
  assign o_hrdata    = st.rdata;
  assign o_hreadyout = !st.rd_wait;
  assign o_hresp     = 1'b0;

  // serial clock pin, driven only in i/o mode with internal clock
  assign o_sclk_out  = st.sclk_out;
  assign o_sclk_oe_n = !(io_mode && !st.sclk_ext);

  assign o_serial_bit_clock = st.src_tick;
  assign o_shift_tick       = st.shift_tick;

  assign o_tx_double = st.buf_double;
  assign o_rx_double = st.buf_double || !io_mode || st.sclk_ext;
  assign o_fifo_en       = fifo_on;
  assign o_rx_fifo_depth = rx_depth;
  assign o_tx_fifo_depth = tx_depth;

endmodule : serial_clock_and_buffer_config
`default_nettype wire

// >>> include/serial_clock_pkg.sv
// constants and types shared by the serial clock and buffer configuration block
package serial_clock_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_BAUD_CONTROL = 8'h00;
  localparam logic [7:0] OFS_BAUD_FRACTION = 8'h04;
  localparam logic [7:0] OFS_MODE_ZERO = 8'h08;
  localparam logic [7:0] OFS_CHANNEL_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_MODE_TWO = 8'h10;
  localparam logic [7:0] OFS_FIFO_CONFIG = 8'h14;
  localparam logic [7:0] OFS_MODE_ONE = 8'h18;
  localparam logic [7:0] OFS_TIMER_COMPARE = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // field positions
  localparam int BRC_N_LSB = 0;
  localparam int BRC_SEL_LSB = 4;
  localparam int BRC_FRAC_BIT = 6;
  localparam int MZ_SRC_LSB = 0;
  localparam int MZ_MODE_LSB = 2;
  localparam int CCR_EXT_BIT = 0;
  localparam int CCR_EDGE_BIT = 1;
  localparam int ST_TXD_BIT = 0;
  localparam int ST_RXD_BIT = 1;
  localparam int ST_FIFO_BIT = 2;
  localparam int ST_RXF_LSB = 4;
  localparam int ST_TXF_LSB = 8;
  localparam int ST_SCLK_BIT = 12;

  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // divider and counter figures
  localparam logic [4:0] FRAC_BASE = 5'h10;
  localparam logic [4:0] N_ZERO_MEANS = 5'h10;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [6:0] TAP_MASK_2 = 7'h01;
  localparam logic [6:0] TAP_MASK_8 = 7'h07;
  localparam logic [6:0] TAP_MASK_32 = 7'h1f;
  localparam logic [6:0] TAP_MASK_128 = 7'h7f;
  localparam logic [2:0] FIFO_FULL_DEPTH = 3'h4;
  localparam logic [2:0] FIFO_HALF_DEPTH = 3'h2;
  localparam logic [1:0] MODE_IO = 2'h0;

  // uart clock sources
  typedef enum logic [1:0] {
    SRC_TIMER = 2'b00,
    SRC_BAUD  = 2'b01,
    SRC_FSYS  = 2'b10,
    SRC_EXT   = 2'b11
  } clk_src_t;

  // fifo arrangements
  typedef enum logic [1:0] {
    DPX_OFF  = 2'b00,
    DPX_RX   = 2'b01,
    DPX_TX   = 2'b10,
    DPX_FULL = 2'b11
  } duplex_t;

endpackage : serial_clock_pkg

// >>> include/div_if.sv
// carrier between the configuration block and its baud divider
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic       tick_in;   // prescaler tap pulse
  logic [3:0] n;         // integer ratio, zero means 16
  logic       frac_en;   // fractional division on
  logic [3:0] k;         // fraction numerator term
  logic       tick_out;  // divided pulse
  modport ctl (output tick_in, output n, output frac_en, output k, input tick_out);
  modport div (input tick_in, input n, input frac_en, input k, output tick_out);
endinterface : div_if
`default_nettype wire

// >>> core/baud_divider.sv
// integer or fractional divider for prescaler tap pulses
`timescale 1ns/1ps
`default_nettype none
module baud_divider
  import serial_clock_pkg::*;
(
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  // divider carrier
  div_if.div        dv
);

  typedef struct packed {
    logic [4:0] cnt;   // input pulses in this period
    logic [3:0] acc;   // fraction accumulator
    logic       lng;   // this period takes one extra pulse
    logic       out;   // output pulse
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic [4:0] len;   // current period length
  logic [4:0] sum;   // accumulator plus step

  // next state of the divider
  always_comb
  begin
    next_st = st;
    next_st.out = 1'b0;
    len = ((dv.n == 4'h0) ? N_ZERO_MEANS : {1'b0, dv.n}) + {4'h0, st.lng};
    sum = {1'b0, st.acc} + (FRAC_BASE - {1'b0, dv.k});
    if (dv.tick_in)
    begin
      if (st.cnt + 5'h01 >= len)
      begin
        next_st.cnt = 5'h00;
        next_st.out = 1'b1;
        if (dv.frac_en)
        begin
          next_st.acc = sum[3:0];
          next_st.lng = sum[4];
        end
        else
        begin
          next_st.acc = 4'h0;
          next_st.lng = 1'b0;
        end
      end
      else
      begin
        next_st.cnt = st.cnt + 5'h01;
      end
    end
  end

  // state register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign dv.tick_out = st.out;

endmodule : baud_divider
`default_nettype wire

// >>> testbench/serial_clock_and_buffer_config_asserts.sv
// port assertions for the serial clock and buffer configuration block
`timescale 1ns/1ps
`default_nettype none
module serial_clock_and_buffer_config_asserts
(
  // clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  // observed outputs
  input wire logic       o_sclk_out,
  input wire logic       o_sclk_oe_n,
  input wire logic       o_shift_tick,
  input wire logic       o_tx_double,
  input wire logic       o_rx_double,
  input wire logic       o_fifo_en,
  input wire logic [2:0] o_rx_fifo_depth,
  input wire logic [2:0] o_tx_fifo_depth
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // receive stays double unless the clock is driven out
  rx_double_a : assert property (o_sclk_oe_n |-> o_rx_double)
    else $error("receive path not double buffered");
  // with driven clock both paths follow the buffer mode
  rx_follow_a : assert property (!o_sclk_oe_n |-> o_rx_double == o_tx_double)
    else $error("receive depth differs from transmit depth");
  // fifo only on top of the double buffer
  fifo_need_a : assert property (o_fifo_en |-> o_tx_double && o_rx_double)
    else $error("fifo on without double buffer");
  // fifo off leaves no bytes to either path
  fifo_off_a : assert property (!o_fifo_en |-> o_rx_fifo_depth == 3'h0 && o_tx_fifo_depth == 3'h0)
    else $error("fifo bytes while fifo off");
  // four bytes shared out, or none
  fifo_split_a : assert property
    (o_fifo_en |-> ({1'b0, o_rx_fifo_depth} + {1'b0, o_tx_fifo_depth}) inside {4'h0, 4'h4})
    else $error("fifo split does not total four bytes");
  // a shift pulse lasts one cycle
  tick_single_a : assert property (o_shift_tick |=> !o_shift_tick)
    else $error("shift pulse longer than one cycle");
  // driven clock is at least a halved baud output
  sclk_half_a : assert property
    (!o_sclk_oe_n && $changed(o_sclk_out) |=> $stable(o_sclk_out))
    else $error("driven clock toggled on consecutive cycles");
  // shifting on the rising driven clock
  sclk_rise_a : assert property (!o_sclk_oe_n && $rose(o_sclk_out) |-> ##[0:1] o_shift_tick)
    else $error("no shift pulse after driven clock rise");
endmodule : serial_clock_and_buffer_config_asserts
`default_nettype wire

// >>> testbench/serial_peer_model.sv
// peer device driving the external serial clock pin
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model
(
  // clock and control
  input  wire logic       i_ref_clk,
  input  wire logic       i_run,
  input  wire logic [7:0] i_half,
  // serial clock pin
  output logic            o_sclk
);
  logic [7:0] cnt; // cycles spent in this half period
  // clock stands low outside frames
  // half period of i_half cycles, not held to any minimum
  always @(posedge i_ref_clk)
  begin
    if (!i_run)
    begin
      o_sclk <= 1'b0;
      cnt    <= 8'h1;
    end
    else if (cnt >= i_half)
    begin
      o_sclk <= ~o_sclk;
      cnt    <= 8'h1;
    end
    else
      cnt <= cnt + 8'h1;
  end
endmodule : serial_peer_model
`default_nettype wire

// >>> testbench/serial_clock_and_buffer_config_test.sv
// self-checking bench for the serial clock and buffer configuration block
`timescale 1ns/1ps
`default_nettype none
module serial_clock_and_buffer_config_test
  import serial_clock_pkg::*;
;
  // bus master side
  logic        i_ref_clk, i_reset, i_hsel, i_hwrite;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [31:0] i_haddr, i_hwdata, rd;
  wire logic   i_hready, i_sclk_in, peer_sclk;
  // design outputs
  wire logic [31:0] o_hrdata;
  wire logic        o_hreadyout, o_hresp, o_sclk_out, o_sclk_oe_n, o_serial_bit_clock;
  wire logic        o_shift_tick, o_tx_double, o_rx_double, o_fifo_en;
  wire logic [2:0]  o_rx_fifo_depth, o_tx_fifo_depth;
  // peer control and bookkeeping
  logic        peer_run;
  logic [7:0]  peer_half;
  int          error_cnt, comparisons, n, m, sc;
  int          lt [2];
  // taps never faster than fsys/2
  // clock cases: mode word, baud word, expected shift period
  logic [31:0] cm [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h6, 32'h5, 32'h5, 32'h4, 32'h7};
  logic [31:0] cb [9] = '{32'h01, 32'h13, 32'h20, 32'h32, 32'h1, 32'h2, 32'h42, 32'h1, 32'h1};
  int          ce [9] = '{4, 48, 1024, 512, 16, 64, 80, 96, 96};
  // single slave, pin level from both drivers
  assign i_hready  = o_hreadyout;
  assign i_sclk_in = o_sclk_oe_n ? peer_sclk : o_sclk_out;
  serial_clock_and_buffer_config dut_u
  (
    .i_ref_clk, .i_reset, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
    .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_sclk_in,
    .o_sclk_out, .o_sclk_oe_n, .o_serial_bit_clock, .o_shift_tick,
    .o_tx_double, .o_rx_double, .o_fifo_en, .o_rx_fifo_depth, .o_tx_fifo_depth
  );
  serial_peer_model peer_u (.i_ref_clk, .i_run(peer_run), .i_half(peer_half), .o_sclk(peer_sclk));
  // fixed 100 MHz clock, no gear change
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // compare and count
  task automatic check(input logic [31:0] v, input logic [31:0] e);
    comparisons++;
    if (v !== e)
    begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, v, e);
    end
  endtask : check
  // one single transfer, held until hready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_hsel   <= 1'b1;
    i_htrans <= 2'b10;
    i_hwrite <= w;
    i_haddr  <= {24'h0, a};
    @(posedge i_ref_clk);
    while (!o_hreadyout) @(posedge i_ref_clk);
    i_hsel   <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= d;
    @(posedge i_ref_clk);
    while (!o_hreadyout) @(posedge i_ref_clk);
    rd = o_hrdata;
    check({31'h0, o_hresp}, 32'h0);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rchk
  // wait for the next shift pulse
  task automatic tick;
    do @(negedge i_ref_clk); while (o_shift_tick !== 1'b1);
  endtask : tick
  // cycles between shift pulses once settled
  task automatic per(output int c);
    c = 0;
    repeat (3) tick();
    sc = 0;
    do
    begin
      @(negedge i_ref_clk);
      c++;
      // source pulses counted over the same period
      if (o_serial_bit_clock === 1'b1) sc++;
    end
    while (o_shift_tick !== 1'b1);
    @(posedge i_ref_clk);
  endtask : per
  // cycles from a peer clock rise to the next shift pulse
  task automatic lat(output int c);
    c = 0;
    do @(negedge i_ref_clk); while (peer_sclk !== 1'b0);
    do @(negedge i_ref_clk); while (peer_sclk !== 1'b1);
    while (o_shift_tick !== 1'b1)
    begin
      @(negedge i_ref_clk);
      c++;
    end
    @(posedge i_ref_clk);
  endtask : lat
  // verdict and end of run
  task automatic conclude;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // hang guard
  initial
  begin
    #400000;
    error_cnt++;
    conclude();
  end
  // main sequence
  initial
  begin
    i_reset     = 1'b1;
    i_hsel      = 1'b0;
    i_htrans    = 2'b00;
    i_hwrite    = 1'b0;
    i_hsize     = 3'h2;
    i_haddr     = 32'h0;
    i_hwdata    = 32'h0;
    peer_run    = 1'b0;
    peer_half   = 8'h3;
    error_cnt   = 0;
    comparisons = 0;
    repeat (4) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(posedge i_ref_clk);
    // reset values, unmapped place, read after write
    rchk(OFS_STATUS, 32'h0);
    rchk(OFS_BAUD_CONTROL, 32'h0);
    rchk(8'h40, 32'h0);
    wr(OFS_TIMER_COMPARE, 32'hffff_0003);
    rchk(OFS_TIMER_COMPARE, 32'h0000_0003);
    wr(OFS_BAUD_FRACTION, 32'h8);
    // buffer depth over mode, clock direction and buffer bit
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_MODE_ZERO, i[0] ? 32'h5 : 32'h0);
      wr(OFS_CHANNEL_CONTROL, {31'h0, i[1]});
      wr(OFS_MODE_TWO, {31'h0, i[2]});
      bus(1'b0, OFS_STATUS, 32'h0);
      check(rd & 32'h7, {29'h0, 1'b0, i[2] | i[1] | i[0], i[2]});
      check({31'h0, o_sclk_oe_n}, {31'h0, i[1] | i[0]});
    end
    // no fifo transfers here, so no clear owed
    // fifo arrangement over buffer bit and duplex codes
    wr(OFS_MODE_ZERO, 32'h0);
    wr(OFS_CHANNEL_CONTROL, 32'h0);
    wr(OFS_FIFO_CONFIG, 32'h1);
    for (int j = 0; j < 8; j++)
    begin
      wr(OFS_MODE_TWO, {31'h0, j[2]});
      wr(OFS_MODE_ONE, {30'h0, j[1:0]});
      bus(1'b0, OFS_STATUS, 32'h0);
      n = j[2] ? (j[1:0] == 1 ? 4 : j[1:0] == 3 ? 2 : 0) : 0;
      m = j[2] ? (j[1:0] == 2 ? 4 : j[1:0] == 3 ? 2 : 0) : 0;
      check(rd & 32'h774, {21'h0, m[2:0], 1'b0, n[2:0], 1'b0, j[2], 2'h0});
    end
    wr(OFS_FIFO_CONFIG, 32'h0);
    // let the write settle before looking at the levels
    @(posedge i_ref_clk);
    check({25'h0, o_fifo_en, o_rx_fifo_depth, o_tx_fifo_depth}, 32'h0);
    // ratio one used only double buffered
    wr(OFS_MODE_TWO, 32'h1);
    // shift pulse period for each clock case
    for (int k = 0; k < 9; k++)
    begin
      peer_run <= (k == 8);
      wr(OFS_CHANNEL_CONTROL, 32'h0);
      wr(OFS_MODE_ZERO, cm[k]);
      wr(OFS_BAUD_CONTROL, cb[k]);
      per(n);
      check(n, ce[k]);
      check(sc, (k < 4) ? 32'd2 : 32'd16);
    end
    // external clock in i/o mode, rising then falling edge
    peer_half <= 8'h6;
    wr(OFS_MODE_ZERO, 32'h0);
    for (int e = 0; e < 2; e++)
    begin
      wr(OFS_CHANNEL_CONTROL, {30'h0, e[0], 1'b1});
      per(n);
      check(n, 32'd12);
      check(sc, 32'd1);
      lat(lt[e]);
    end
    check(lt[1] - lt[0], 32'd6);
    peer_run <= 1'b0;
    conclude();
  end
endmodule : serial_clock_and_buffer_config_test
bind serial_clock_and_buffer_config serial_clock_and_buffer_config_asserts chk_u
(
  .i_ref_clk, .i_reset, .o_sclk_out, .o_sclk_oe_n, .o_shift_tick,
  .o_tx_double, .o_rx_double, .o_fifo_en, .o_rx_fifo_depth, .o_tx_fifo_depth
);
`default_nettype wire
